/* File: rtl/agc_consts.svh */
// Register offsets, field positions, reset values and timing counts of the gain loop
`ifndef AGC_CONSTS_SVH
`define AGC_CONSTS_SVH

`define AGC_OFS_CTRL 8'h00
`define AGC_OFS_SETPOINT 8'h04
`define AGC_OFS_DEADBAND 8'h08
`define AGC_OFS_LOOPSHIFT 8'h0c
`define AGC_OFS_INIT_A 8'h10
`define AGC_OFS_INIT_B 8'h14
`define AGC_OFS_COMP_DLY 8'h18
`define AGC_OFS_STATUS 8'h1c
`define AGC_OFS_LEVEL_A 8'h20
`define AGC_OFS_LEVEL_B 8'h24

`define AGC_CTRL_FREEZE 0
`define AGC_CTRL_STROBE_EN 1
`define AGC_CTRL_ORDER_LO 2
`define AGC_CTRL_ORDER_HI 4

`define AGC_STAT_OVF 0

`define AGC_RST_CTRL 5'h00
`define AGC_RST_SETPOINT 12'h400
`define AGC_RST_DEADBAND 12'h200
`define AGC_RST_LOOPSHIFT 4'h4
`define AGC_RST_INIT_GAIN 3'h0
`define AGC_RST_COMP_DLY 4'h6

`define AGC_FIXED_DLY 6
`define AGC_MAX_EXTRA 15
`define AGC_CHAIN_LEN 21
`define AGC_MAX_GAIN 3'h7
`define AGC_COMB_STAGES 4
`define AGC_FIFO_DEPTH 32

`endif

/* File: rtl/agc_pkg.sv */
// Types shared by the gain loop, its monitor, the amplifier model and the bench
package agc_pkg;
	typedef logic [11:0] agc_adc_t;
	typedef logic [2:0] agc_gain_t;
	typedef logic signed [18:0] agc_fixed_t;
	typedef struct packed {
		agc_fixed_t chan_a;
		agc_fixed_t chan_b;
	} agc_pair_t;
	typedef struct packed {
		logic [7:0] addr;
		logic [15:0] wdata;
		logic wr;
		logic rd;
	} agc_bus_req_t;
endpackage

/* File: rtl/agc_fifo.sv */
// Synchronous FIFO with valid/ready on both sides and registered flags
`timescale 1ns/1ps
module agc_fifo #(
	parameter int WIDTH = 38,
	parameter int DEPTH = 32
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [WIDTH-1:0] in_data,
	input wire logic in_valid,
	output logic in_ready,
	output logic [WIDTH-1:0] out_data,
	output logic out_valid,
	input wire logic out_ready
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr_q;
	logic [AW-1:0] rd_ptr_q;
	logic [AW:0] count_q;
	logic [AW:0] count_d;
	logic full_q;
	logic empty_q;
	wire logic push = in_valid & ~full_q;
	wire logic pop = out_ready & ~empty_q;

	assign count_d = count_q + (AW+1)'(push) - (AW+1)'(pop);
	assign in_ready = ~full_q;
	assign out_valid = ~empty_q;
	assign out_data = mem[rd_ptr_q];

	always_ff @(posedge clk)
	begin
		if (push)
		begin
			mem[wr_ptr_q] <= in_data;
		end
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			wr_ptr_q <= '0;
			rd_ptr_q <= '0;
			count_q <= '0;
			full_q <= 1'b0;
			empty_q <= 1'b1;
		end
		else
		begin
			wr_ptr_q <= wr_ptr_q + AW'(push);
			rd_ptr_q <= rd_ptr_q + AW'(pop);
			count_q <= count_d;
			full_q <= (count_d == (AW+1)'(DEPTH));
			empty_q <= (count_d == '0);
		end
	end
endmodule

/* File: rtl/agc_gain_loop.sv */
// Dual-channel gain loop with detector, amplifier control and gain compensation
//
// The register offsets and the plain strobed port were decided locally.
`timescale 1ns/1ps
`include "agc_consts.svh"

module agc_gain_loop
	import agc_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic [7:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [15:0] reg_rdata,
	input wire agc_adc_t adc_a,
	input wire agc_adc_t adc_b,
	input wire logic adc_valid,
	output logic adc_ready,
	output agc_gain_t amp_a_gain,
	output agc_gain_t amp_b_gain,
	output logic amp_a_latch_strobe,
	output logic amp_b_latch_strobe,
	output agc_pair_t out_data,
	output logic out_valid,
	input wire logic out_ready
);
	logic [4:0] ctrl_q;
	logic [11:0] setpoint_q;
	logic [11:0] deadband_q;
	logic [3:0] loop_shift_q;
	agc_gain_t chan_a_initial_gain;
	agc_gain_t chan_b_initial_gain;
	logic [3:0] gain_comp_delay;
	logic ovf_q;
	logic [15:0] rdata_q;

	logic [11:0] samp_q [2];
	logic samp_valid_q;
	logic [11:0] comb_q [2][`AGC_COMB_STAGES+1];
	logic [15:0] integ_q [2];
	agc_gain_t chain_q [2][`AGC_CHAIN_LEN];
	agc_gain_t amp_gain_q [2];
	logic strobe_q [2];
	agc_fixed_t fixed [2];

	wire logic gain_freeze_bit = ctrl_q[`AGC_CTRL_FREEZE];
	wire logic strobe_en = ctrl_q[`AGC_CTRL_STROBE_EN];
	wire logic [2:0] detector_comb_order = ctrl_q[`AGC_CTRL_ORDER_HI:`AGC_CTRL_ORDER_LO];
	wire logic [2:0] order_sel = (detector_comb_order > 3'(`AGC_COMB_STAGES)) ? 3'(`AGC_COMB_STAGES)
		: detector_comb_order;
	// Converter of seven clocks plus filter sits behind the amplifier
	// Deepest tap is the fixed path less one plus the largest extra delay
	wire logic [4:0] tap_sel = 5'(`AGC_FIXED_DLY - 1)
		+ {1'b0, gain_comp_delay};
	wire logic fifo_in_ready;
	wire logic ovf_set = samp_valid_q & ~fifo_in_ready;

	function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
		hit = (a == ofs);
	endfunction

	// Most negative code folds to the largest positive magnitude
	function automatic logic [11:0] magnitude(input logic [11:0] s);
		logic [11:0] neg;
		neg = 12'h000 - s;
		if (!s[11])
		begin
			magnitude = s;
		end
		else if (s == 12'h800)
		begin
			magnitude = 12'h7ff;
		end
		else
		begin
			magnitude = neg;
		end
	endfunction

	wire logic wr_ctrl = reg_wr & hit(reg_addr, `AGC_OFS_CTRL);
	wire logic wr_setpoint = reg_wr & hit(reg_addr, `AGC_OFS_SETPOINT);
	wire logic wr_deadband = reg_wr & hit(reg_addr, `AGC_OFS_DEADBAND);
	wire logic wr_shift = reg_wr & hit(reg_addr, `AGC_OFS_LOOPSHIFT);
	wire logic wr_init_a = reg_wr & hit(reg_addr, `AGC_OFS_INIT_A);
	wire logic wr_init_b = reg_wr & hit(reg_addr, `AGC_OFS_INIT_B);
	wire logic wr_dly = reg_wr & hit(reg_addr, `AGC_OFS_COMP_DLY);
	wire logic wr_status = reg_wr & hit(reg_addr, `AGC_OFS_STATUS);
	wire logic ovf_clr = wr_status & reg_wdata[`AGC_STAT_OVF];

	wire logic [15:0] status_word = {7'h00, gain_freeze_bit, 1'b0, amp_gain_q[1], amp_gain_q[0], ovf_q};
	wire logic [15:0] rd_mux =
		hit(reg_addr, `AGC_OFS_CTRL) ? {11'h000, ctrl_q} :
		hit(reg_addr, `AGC_OFS_SETPOINT) ? {4'h0, setpoint_q} :
		hit(reg_addr, `AGC_OFS_DEADBAND) ? {4'h0, deadband_q} :
		hit(reg_addr, `AGC_OFS_LOOPSHIFT) ? {12'h000, loop_shift_q} :
		hit(reg_addr, `AGC_OFS_INIT_A) ? {13'h0000, chan_a_initial_gain} :
		hit(reg_addr, `AGC_OFS_INIT_B) ? {13'h0000, chan_b_initial_gain} :
		hit(reg_addr, `AGC_OFS_COMP_DLY) ? {12'h000, gain_comp_delay} :
		hit(reg_addr, `AGC_OFS_STATUS) ? status_word :
		hit(reg_addr, `AGC_OFS_LEVEL_A) ? {4'h0, comb_q[0][order_sel]} :
		hit(reg_addr, `AGC_OFS_LEVEL_B) ? {4'h0, comb_q[1][order_sel]} :
		16'h0000;

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			ctrl_q <= `AGC_RST_CTRL;
			setpoint_q <= `AGC_RST_SETPOINT;
			deadband_q <= `AGC_RST_DEADBAND;
			loop_shift_q <= `AGC_RST_LOOPSHIFT;
			chan_a_initial_gain <= `AGC_RST_INIT_GAIN;
			chan_b_initial_gain <= `AGC_RST_INIT_GAIN;
			gain_comp_delay <= `AGC_RST_COMP_DLY;
		end
		else
		begin
			if (wr_ctrl)
			begin
				ctrl_q <= reg_wdata[4:0];
			end
			if (wr_setpoint)
			begin
				setpoint_q <= reg_wdata[11:0];
			end
			if (wr_deadband)
			begin
				deadband_q <= reg_wdata[11:0];
			end
			if (wr_shift)
			begin
				loop_shift_q <= reg_wdata[3:0];
			end
			if (wr_init_a)
			begin
				chan_a_initial_gain <= reg_wdata[2:0];
			end
			if (wr_init_b)
			begin
				chan_b_initial_gain <= reg_wdata[2:0];
			end
			if (wr_dly)
			begin
				gain_comp_delay <= reg_wdata[3:0];
			end
		end
	end

	// Read data stands only in the cycle after the strobe
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			rdata_q <= 16'h0000;
			ovf_q <= 1'b0;
		end
		else
		begin
			rdata_q <= reg_rd ? rd_mux : 16'h0000;
			// A drop in the clearing cycle still latches
			ovf_q <= ovf_set | (ovf_q & ~ovf_clr);
		end
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			samp_valid_q <= 1'b0;
		end
		else
		begin
			samp_valid_q <= adc_valid;
		end
	end

	genvar c;
	genvar k;
	generate
		for (c = 0; c < 2; c++)
		begin : g_chan
			wire logic [11:0] adc_in = (c == 0) ? adc_a : adc_b;
			wire agc_gain_t init_gain = (c == 0) ? chan_a_initial_gain : chan_b_initial_gain;
			wire logic [11:0] level = comb_q[c][order_sel];
			wire logic signed [12:0] err = $signed({1'b0, level}) - $signed({1'b0, setpoint_q});
			wire logic over = err > $signed({1'b0, deadband_q});
			wire logic under = err < -$signed({1'b0, deadband_q});
			wire logic [15:0] step = 16'h0001 << loop_shift_q;
			// Integrator saturates rather than wraps, so the code never jumps end to end
			wire logic [16:0] up_sum = {1'b0, integ_q[c]} + {1'b0, step};
			wire logic [15:0] up_val = up_sum[16] ? 16'hffff : up_sum[15:0];
			wire logic [15:0] dn_val = (integ_q[c] < step) ? 16'h0000 : integ_q[c] - step;
			wire logic [15:0] adapt_val = over ? dn_val
				: under ? up_val
				: integ_q[c];
			// Freeze reloads every clock, so a new initial gain applies at once
			wire logic [15:0] integ_d = gain_freeze_bit ? {init_gain, 13'h0000}
				: adapt_val;
			wire agc_gain_t integ_gain = integ_q[c][15:13];
			wire agc_gain_t comp_gain = chain_q[c][tap_sel];
			wire logic [2:0] undo_shift = `AGC_MAX_GAIN - comp_gain;
			wire agc_fixed_t samp_ext = {{7{samp_q[c][11]}}, samp_q[c]};

			// Lower gain means a quieter input: shift it back up
			assign fixed[c] = samp_ext <<< undo_shift;

			always_ff @(posedge clk or posedge rst)
			begin
				if (rst)
				begin
					samp_q[c] <= 12'h000;
					comb_q[c][0] <= 12'h000;
					integ_q[c] <= 16'h0000;
					amp_gain_q[c] <= 3'h0;
					strobe_q[c] <= 1'b0;
				end
				else
				begin
					samp_q[c] <= adc_in;
					comb_q[c][0] <= magnitude(adc_in);
					integ_q[c] <= integ_d;
					amp_gain_q[c] <= integ_gain;
					// Strobe marks the cycle a new code reaches the amplifier
					strobe_q[c] <= strobe_en & (integ_gain != amp_gain_q[c]);
				end
			end

			// Each stage is a leaky average; more stages narrow the detector
			for (k = 1; k <= `AGC_COMB_STAGES; k++)
			begin : g_comb
				wire logic signed [12:0] diff = $signed({1'b0, comb_q[c][k-1]}) - $signed({1'b0, comb_q[c][k]});
				wire logic signed [12:0] upd = $signed({1'b0, comb_q[c][k]}) + (diff >>> 2);
				always_ff @(posedge clk or posedge rst)
				begin
					if (rst)
					begin
						comb_q[c][k] <= 12'h000;
					end
					else
					begin
						comb_q[c][k] <= upd[11:0];
					end
				end
			end

			// Cleared on reset so no stale code is undone after release
			for (k = 0; k < `AGC_CHAIN_LEN; k++)
			begin : g_chain
				wire agc_gain_t src = (k == 0) ? integ_gain : chain_q[c][(k == 0) ? 0 : k-1];
				always_ff @(posedge clk or posedge rst)
				begin
					if (rst)
					begin
						chain_q[c][k] <= 3'h0;
					end
					else
					begin
						chain_q[c][k] <= src;
					end
				end
			end
		end
	endgenerate

	// Words arriving while full are dropped and flagged; adc_ready falls while full but capture goes on
	agc_fifo #(
		.WIDTH($bits(agc_pair_t)),
		.DEPTH(`AGC_FIFO_DEPTH)
	) u_fifo (
		.clk(clk),
		.rst(rst),
		.in_data({fixed[0], fixed[1]}),
		.in_valid(samp_valid_q),
		.in_ready(fifo_in_ready),
		.out_data(out_data),
		.out_valid(out_valid),
		.out_ready(out_ready)
	);

	assign reg_rdata = rdata_q;
	assign adc_ready = fifo_in_ready;
	assign amp_a_gain = amp_gain_q[0];
	assign amp_b_gain = amp_gain_q[1];
	assign amp_a_latch_strobe = strobe_q[0];
	assign amp_b_latch_strobe = strobe_q[1];
endmodule

/* File: tb/agc_gain_loop_monitor.sv */
// Port checker for the gain loop
`timescale 1ns/1ps
module agc_gain_loop_monitor
	import agc_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic [7:0] reg_addr,
	input wire logic reg_rd,
	input wire logic [15:0] reg_rdata,
	input wire logic adc_valid,
	input wire logic adc_ready,
	input wire agc_gain_t amp_a_gain,
	input wire agc_gain_t amp_b_gain,
	input wire logic amp_a_latch_strobe,
	input wire logic amp_b_latch_strobe,
	input wire agc_pair_t out_data,
	input wire logic out_valid,
	input wire logic out_ready
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	sequence s_stalled;
		out_valid && !out_ready;
	endsequence
	sequence s_head_kept;
		out_valid && $stable(out_data);
	endsequence
	chk_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
		else $error("read data outside answer cycle");
	chk_unmapped_zero: assert property ($past(reg_rd) && $past(reg_addr) >= 8'h28 |-> reg_rdata == 16'h0000)
		else $error("unmapped read not zero");
	chk_strobe_a_change: assert property (amp_a_latch_strobe |-> amp_a_gain != $past(amp_a_gain))
		else $error("strobe a without gain change");
	chk_strobe_b_change: assert property (amp_b_latch_strobe |-> amp_b_gain != $past(amp_b_gain))
		else $error("strobe b without gain change");
	chk_full_not_empty: assert property (!adc_ready |-> out_valid)
		else $error("full buffer shows no data");
	chk_head_held: assert property (s_stalled |=> s_head_kept)
		else $error("stalled head changed");
	chk_push_shows: assert property (adc_valid |-> ##2 out_valid)
		else $error("sample did not reach output");
	chk_reset_gain: assert property ($fell(rst) |-> amp_a_gain == 3'h0 && amp_b_gain == 3'h0)
		else $error("gain not cleared by reset");
endmodule

bind agc_gain_loop agc_gain_loop_monitor u_mon (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_rd(reg_rd),
	.reg_rdata(reg_rdata), .adc_valid(adc_valid), .adc_ready(adc_ready), .amp_a_gain(amp_a_gain),
	.amp_b_gain(amp_b_gain), .amp_a_latch_strobe(amp_a_latch_strobe), .amp_b_latch_strobe(amp_b_latch_strobe),
	.out_data(out_data), .out_valid(out_valid), .out_ready(out_ready));

/* File: tb/agc_amp_model.sv */
// Stepped-gain amplifier, filter and converter ahead of the gain loop
`timescale 1ns/1ps
module agc_amp_model
	import agc_pkg::*;
#(
	parameter int CONV_LAT = 7
) (
	input wire logic clk,
	input wire logic rst,
	input wire agc_gain_t gain_a,
	input wire agc_gain_t gain_b,
	input wire agc_fixed_t sig_a,
	input wire agc_fixed_t sig_b,
	output agc_adc_t adc_a,
	output agc_adc_t adc_b
);
	// Three extra clocks: amplifier, filter and capture
	localparam int L = CONV_LAT + 3;
	logic [3*L-1:0] pa_q;
	logic [3*L-1:0] pb_q;
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			pa_q <= '0;
			pb_q <= '0;
		end
		else
		begin
			pa_q <= {pa_q[3*L-4:0], gain_a};
			pb_q <= {pb_q[3*L-4:0], gain_b};
		end
	end
	// Each code below 7 halves the level
	assign adc_a = agc_adc_t'(sig_a >>> (3'h7 - pa_q[3*L-1 -: 3]));
	assign adc_b = agc_adc_t'(sig_b >>> (3'h7 - pb_q[3*L-1 -: 3]));
endmodule

/* File: tb/tb_agc_gain_loop.sv */
// Self-checking bench for the gain loop
`timescale 1ns/1ps
module tb_agc_gain_loop
	import agc_pkg::*;
;
	logic clk, rst, reg_wr, reg_rd, adc_valid, adc_ready, out_valid, out_ready, v;
	logic amp_a_latch_strobe, amp_b_latch_strobe;
	logic [7:0] reg_addr;
	logic [15:0] reg_wdata, reg_rdata, rv;
	agc_adc_t adc_a, adc_b;
	agc_gain_t amp_a_gain, amp_b_gain, ga, gb;
	agc_pair_t out_data;
	agc_fixed_t sig_a, sig_b;
	int bad_count, checks, n, na, nb, k;
	logic [7:0] ra [9] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h1c, 8'h30};
	logic [15:0] re [9] = '{16'h0000, 16'h0400, 16'h0200, 16'h0004, 16'h0000, 16'h0000, 16'h0006, 16'h0000, 16'h0000};
	int dl [3] = '{6, 3, 0};
	agc_gain_loop u_agc_gain_loop (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .adc_a(adc_a), .adc_b(adc_b),
		.adc_valid(adc_valid), .adc_ready(adc_ready), .amp_a_gain(amp_a_gain), .amp_b_gain(amp_b_gain),
		.amp_a_latch_strobe(amp_a_latch_strobe), .amp_b_latch_strobe(amp_b_latch_strobe),
		.out_data(out_data), .out_valid(out_valid), .out_ready(out_ready));
	agc_amp_model u_agc_amp_model (.clk(clk), .rst(rst), .gain_a(amp_a_gain), .gain_b(amp_b_gain),
		.sig_a(sig_a), .sig_b(sig_b), .adc_a(adc_a), .adc_b(adc_b));
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	function automatic logic [15:0] stat(logic f, agc_gain_t a, agc_gain_t b);
		return {7'h00, f, 1'b0, b, a, 1'b0};
	endfunction
	task automatic chk(input string nm, input logic [18:0] e, input logic [18:0] g);
		checks++;
		if (g !== e)
		begin
			bad_count++;
			$display("FAIL %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
		@(posedge clk);
	endtask
	task automatic rd(input logic [7:0] a);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 rv = reg_rdata;
		@(posedge clk);
	endtask
	task automatic conclude();
		$display("checks %0d mismatches %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	initial
	begin
		{rst, out_ready} = 2'b11;
		{reg_wr, reg_rd, adc_valid, reg_addr, reg_wdata} = '0;
		{sig_a, sig_b, bad_count, checks} = '0;
		void'($urandom(78016));
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		foreach (ra[i])
		begin
			rd(ra[i]);
			chk("reset read", re[i], 19'(rv));
		end
		repeat (3)
		begin
			n = $urandom % 4096;
			wr(8'h04, 16'(n));
			rd(8'h04);
			chk("setpoint", 19'(n), 19'(rv));
		end
		wr(8'h04, 16'h0400);
		$display("test registers done");
		sig_a <= 19'h0_0400;
		sig_b <= 19'h7_fe00;
		adc_valid <= 1'b1;
		ga = 3'h5;
		gb = 3'h2;
		wr(8'h10, 16'(ga));
		wr(8'h14, 16'(gb));
		wr(8'h00, 16'h0003);
		repeat (40) @(posedge clk);
		foreach (dl[i])
		begin
			wr(8'h18, 16'(dl[i]));
			// Step both directions across the loop
			ga = ga ^ 3'h2;
			gb = gb ^ 3'h6;
			wr(8'h10, 16'(ga));
			wr(8'h14, 16'(gb));
			{na, nb} = '0;
			repeat (40)
			begin
				@(posedge clk);
				#1 na += (out_valid === 1'b1 && out_data.chan_a !== 19'h0_0400);
				nb += (out_valid === 1'b1 && out_data.chan_b !== 19'h7_fe00);
			end
			chk("misaligned a", 19'(6 - dl[i]), 19'(na));
			chk("misaligned b", 19'(6 - dl[i]), 19'(nb));
			chk("gain a", 19'(ga), 19'(amp_a_gain));
			chk("gain b", 19'(gb), 19'(amp_b_gain));
		end
		rd(8'h1c);
		chk("frozen status", 19'(stat(1'b1, ga, gb)), 19'(rv & 16'hfffe));
		$display("test freeze done");
		sig_a <= 19'h0_0780;
		wr(8'h0c, 16'h0006);
		wr(8'h00, 16'h0012);
		repeat (800) @(posedge clk);
		chk("run gain a", 19'h6, 19'(amp_a_gain));
		chk("run gain b", 19'h7, 19'(amp_b_gain));
		rd(8'h1c);
		chk("run status", 19'(stat(1'b0, 3'h6, 3'h7)), 19'(rv & 16'hfffe));
		rd(8'h20);
		chk("level a", 19'h0_03c0, 19'(rv));
		$display("test free run done");
		out_ready <= 1'b0;
		repeat (40) @(posedge clk);
		chk("ready when full", 19'h0, 19'(adc_ready));
		adc_valid <= 1'b0;
		repeat (2) @(posedge clk);
		n = 0;
		v = out_valid;
		for (k = 0; k < 300 && v === 1'b1; k++)
		begin
			@(posedge clk);
			n += (out_ready === 1'b1);
			out_ready <= 1'($urandom);
			#1 v = out_valid;
		end
		bad_count += (k == 300);
		out_ready <= 1'b1;
		chk("drained words", 19'h20, 19'(n));
		rd(8'h1c);
		chk("overflow set", 19'h1, 19'(rv[0]));
		wr(8'h1c, 16'h0001);
		rd(8'h1c);
		chk("overflow clear", 19'h0, 19'(rv[0]));
		$display("test buffer done");
		conclude();
	end
endmodule
